// >>> verilog/diag_pkg.sv
// constants for the bus diagnostic and transmit event fifo block
// assumes a single clock domain and the simple register port of the top
package diag_pkg;
    // ----------------------------------------
    // register indices
    // ----------------------------------------
    localparam logic [2:0] IDX_COUNTS = 3'h0;
    localparam logic [2:0] IDX_FLAGS = 3'h1;
    localparam logic [2:0] IDX_TEFCON = 3'h2;
    localparam logic [2:0] IDX_TEFSTA = 3'h3;
    localparam logic [2:0] IDX_EVENT_TAIL_ADDRESS = 3'h4;
    localparam logic [2:0] IDX_STAMP = 3'h5;
    // ----------------------------------------
    // field layout
    // ----------------------------------------
    localparam int CNT_W = 8;
    localparam int NUM_CNT = 4;
    localparam int CLEAN_W = 16;
    localparam int FLAG_LSB = 16;
    localparam int FLAG_W = 16;
    localparam logic [15:0] FLAG_MASK = 16'hfbbf;
    localparam int DEPTH_LSB = 24;
    localparam int DEPTH_W = 5;
    localparam int RESET_BIT = 10;
    localparam int ADV_BIT = 8;
    localparam int STAMP_BIT = 5;
    localparam int IE_W = 4;
    localparam int OV_BIT = 3;
    localparam int FULL_BIT = 2;
    localparam int HALF_BIT = 1;
    localparam int NE_BIT = 0;
    localparam int FILL_W = 6;
    // ----------------------------------------
    // event fifo placement in message memory
    // ----------------------------------------
    localparam logic [31:0] TEF_BASE = 32'h0000_0400;
    localparam logic [31:0] ENTRY_PLAIN = 32'h0000_0008;
    localparam logic [31:0] ENTRY_STAMPED = 32'h0000_000c;
    localparam logic [FILL_W-1:0] FILL_ONE = 6'h01;
    typedef enum logic {TEF_RESET, TEF_RUN} tef_state_type;
endpackage

// >>> verilog/stamp_if.sv
// write and read port of the event stamp store
// assumes the top drives writes and the store answers reads
interface stamp_if;
    logic wr_en;
    logic [4:0] wr_addr;
    logic [31:0] wr_data;
    logic [4:0] rd_addr;
    logic [31:0] rd_data;
    modport user (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
    modport store (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// >>> verilog/stamp_store.sv
// thirty-two word store for event time stamps
// assumes rd_data is wanted one cycle after rd_addr
module stamp_store (
    input wire logic clk, // controller clock
    stamp_if.store port // write and read port
);
    logic [31:0] mem_q [32];
    logic [31:0] rd_d;
    logic [31:0] rd_q;

    // registered read, so the data path leaves a flop
    always_comb begin
        rd_d = mem_q[port.rd_addr];
    end

    always_ff @(posedge clk) begin
        rd_q <= rd_d;
        if (port.wr_en) begin
            mem_q[port.wr_addr] <= port.wr_data;
        end
    end

    assign port.rd_data = rd_q;
endmodule

// >>> verilog/sat_counter.sv
// software writable counter that stops at its top value
// assumes inc is a one-cycle pulse per counted event
module sat_counter #(
    parameter int W = 8
) (
    input wire logic clk, // controller clock
    input wire logic rstn, // async reset, active low
    input wire logic wr, // software write
    input wire logic [W-1:0] wdata, // value written
    input wire logic inc, // count one event
    output logic [W-1:0] q // current count
);
    logic [W-1:0] q_d;
    logic [W-1:0] q_q;

    // a write wins over a same-cycle event; saturate rather than wrap
    always_comb begin
        q_d = q_q;
        if (wr) begin
            q_d = wdata;
        end else if (inc && (q_q != '1)) begin
            q_d = q_q + W'(1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q_q <= '0;
        end else begin
            q_q <= q_d;
        end
    end

    assign q = q_q;
endmodule

// >>> verilog/can_diag_tef.sv
// bus diagnostic counters and flags plus transmit event fifo control
// assumes the protocol engine gives one-cycle event pulses on clk
module can_diag_tef (
    input wire logic clk, // controller clock, 25 MHz
    input wire logic rstn, // async reset, active low
    input wire logic reg_wr, // register write strobe
    input wire logic [2:0] reg_addr, // register index
    input wire logic [31:0] reg_wdata, // write data
    input wire logic config_mode, // high while in configuration mode
    input wire logic [3:0] err_inc, // fast tx, fast rx, arb tx, arb rx
    input wire logic clean_msg, // message done without error
    input wire logic [15:0] flag_set, // flag events, aligned to bits 31:16
    input wire logic tef_push, // transmit event to store
    input wire logic [31:0] time_base, // running time stamp
    output logic [31:0] reg_rdata, // registered read data
    output logic tef_irq // gated event fifo interrupt
);
    // ----------------------------------------
    // register port decode
    // ----------------------------------------
    function automatic logic hit(input logic wr, input logic [2:0] a,
                                 input logic [2:0] idx);
        hit = wr && (a == idx);
    endfunction

    logic wr_counts;
    logic wr_flags;
    logic wr_con;
    logic wr_sta;
    assign wr_counts = hit(reg_wr, reg_addr, diag_pkg::IDX_COUNTS);
    assign wr_flags = hit(reg_wr, reg_addr, diag_pkg::IDX_FLAGS);
    assign wr_con = hit(reg_wr, reg_addr, diag_pkg::IDX_TEFCON);
    assign wr_sta = hit(reg_wr, reg_addr, diag_pkg::IDX_TEFSTA);

    // ----------------------------------------
    // error counters
    // ----------------------------------------
    logic [diag_pkg::CNT_W-1:0] cnt [diag_pkg::NUM_CNT];
    logic [diag_pkg::CLEAN_W-1:0] clean_cnt;

    // one saturating counter per phase and direction
    for (genvar i = 0; i < diag_pkg::NUM_CNT; i++) begin : g_cnt
        sat_counter #(.W(diag_pkg::CNT_W)) u_cnt (
            .clk(clk),
            .rstn(rstn),
            .wr(wr_counts),
            .wdata(reg_wdata[i*diag_pkg::CNT_W +: diag_pkg::CNT_W]),
            .inc(err_inc[i]),
            .q(cnt[i])
        );
    end

    sat_counter #(.W(diag_pkg::CLEAN_W)) u_clean (
        .clk(clk),
        .rstn(rstn),
        .wr(wr_flags),
        .wdata(reg_wdata[diag_pkg::CLEAN_W-1:0]),
        .inc(clean_msg),
        .q(clean_cnt)
    );

    // ----------------------------------------
    // diagnostic flags
    // ----------------------------------------
    logic [15:0] flags_d;
    logic [15:0] flags_q;

    // a new event wins over a software clear in the same cycle
    always_comb begin
        flags_d = flags_q;
        if (wr_flags) begin
            flags_d = reg_wdata[diag_pkg::FLAG_LSB +: diag_pkg::FLAG_W];
        end
        flags_d = (flags_d | flag_set) & diag_pkg::FLAG_MASK;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ----------------------------------------
    // event fifo control and pointers
    // ----------------------------------------
    diag_pkg::tef_state_type state_d, state_q;
    logic [diag_pkg::DEPTH_W-1:0] depth_d, depth_q;
    logic stamp_en_d, stamp_en_q;
    logic [diag_pkg::IE_W-1:0] ie_d, ie_q;
    logic ov_d, ov_q;
    logic [4:0] head_d, head_q;
    logic [4:0] tail_d, tail_q;
    logic [diag_pkg::FILL_W-1:0] fill_d, fill_q;
    logic [diag_pkg::FILL_W-1:0] size;
    logic full;
    logic half;
    logic nonempty;
    logic do_push;
    logic do_pop;

    assign size = diag_pkg::FILL_W'(depth_q) + diag_pkg::FILL_ONE;
    assign full = (fill_q == size);
    assign half = ({fill_q, 1'b0} >= {1'b0, size});
    assign nonempty = (fill_q != '0);
    assign do_push = tef_push && (state_q == diag_pkg::TEF_RUN) && !full;
    assign do_pop = wr_con && reg_wdata[diag_pkg::ADV_BIT] && nonempty
        && (state_q == diag_pkg::TEF_RUN);

    // pointers wrap at the configured size, not at the store size
    always_comb begin
        state_d = state_q;
        depth_d = depth_q;
        stamp_en_d = stamp_en_q;
        ie_d = ie_q;
        ov_d = ov_q;
        head_d = head_q;
        tail_d = tail_q;
        fill_d = fill_q;
        if (wr_con) begin
            ie_d = reg_wdata[diag_pkg::IE_W-1:0];
            if (config_mode) begin
                depth_d = reg_wdata[diag_pkg::DEPTH_LSB +: diag_pkg::DEPTH_W];
                stamp_en_d = reg_wdata[diag_pkg::STAMP_BIT];
            end
        end
        if (wr_sta && !reg_wdata[diag_pkg::OV_BIT]) begin
            ov_d = 1'b0;
        end
        case (state_q)
            diag_pkg::TEF_RESET: begin
                head_d = '0;
                tail_d = '0;
                fill_d = '0;
                if (!config_mode) begin
                    state_d = diag_pkg::TEF_RUN;
                end
            end
            default: begin
                if (do_push) begin
                    head_d = (head_q == 5'(depth_q)) ? '0 : head_q + 5'h01;
                end
                if (do_pop) begin
                    tail_d = (tail_q == 5'(depth_q)) ? '0 : tail_q + 5'h01;
                end
                fill_d = fill_q + diag_pkg::FILL_W'(do_push)
                    - diag_pkg::FILL_W'(do_pop);
                if (config_mode || (wr_con && reg_wdata[diag_pkg::RESET_BIT])) begin
                    state_d = diag_pkg::TEF_RESET;
                end
            end
        endcase
        if (tef_push && full && (state_q == diag_pkg::TEF_RUN)) begin
            ov_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= diag_pkg::TEF_RESET;
            depth_q <= '0;
            stamp_en_q <= 1'b0;
            ie_q <= '0;
            ov_q <= 1'b0;
            head_q <= '0;
            tail_q <= '0;
            fill_q <= '0;
        end else begin
            state_q <= state_d;
            depth_q <= depth_d;
            stamp_en_q <= stamp_en_d;
            ie_q <= ie_d;
            ov_q <= ov_d;
            head_q <= head_d;
            tail_q <= tail_d;
            fill_q <= fill_d;
        end
    end

    // ----------------------------------------
    // stamp store
    // ----------------------------------------
    stamp_if sif ();
    assign sif.wr_en = do_push && stamp_en_q;
    assign sif.wr_addr = head_q;
    assign sif.wr_data = time_base;
    assign sif.rd_addr = tail_q;

    stamp_store u_store (
        .clk(clk),
        .port(sif)
    );

    // ----------------------------------------
    // read mux and interrupt
    // ----------------------------------------
    logic [3:0] sta;
    logic [31:0] entry;
    logic [31:0] rdata_d, rdata_q;
    logic irq_d, irq_q;

    assign sta = {ov_q, full, half, nonempty};
    assign entry = stamp_en_q ? diag_pkg::ENTRY_STAMPED : diag_pkg::ENTRY_PLAIN;

    // reset bit reads back as live status, not a stored value; advance bit reads back as zero
    always_comb begin
        rdata_d = '0;
        if (reg_addr == diag_pkg::IDX_COUNTS) begin
            rdata_d = {cnt[3], cnt[2], cnt[1], cnt[0]};
        end else if (reg_addr == diag_pkg::IDX_FLAGS) begin
            rdata_d = {flags_q, clean_cnt};
        end else if (reg_addr == diag_pkg::IDX_TEFCON) begin
            rdata_d[diag_pkg::DEPTH_LSB +: diag_pkg::DEPTH_W] = depth_q;
            rdata_d[diag_pkg::RESET_BIT] = (state_q == diag_pkg::TEF_RESET);
            rdata_d[diag_pkg::STAMP_BIT] = stamp_en_q;
            rdata_d[diag_pkg::IE_W-1:0] = ie_q;
        end else if (reg_addr == diag_pkg::IDX_TEFSTA) begin
            rdata_d[diag_pkg::IE_W-1:0] = sta;
        end else if (reg_addr == diag_pkg::IDX_EVENT_TAIL_ADDRESS) begin
            rdata_d = diag_pkg::TEF_BASE + 32'(tail_q) * entry;
        end else if (reg_addr == diag_pkg::IDX_STAMP) begin
            rdata_d = sif.rd_data;
        end
        irq_d = |(sta & ie_q);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= '0;
            irq_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign tef_irq = irq_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_reset_leave;
        (state_q == diag_pkg::TEF_RESET) && !config_mode;
    endsequence

    sequence s_run_empty;
        (state_q == diag_pkg::TEF_RUN) && (fill_q == '0) && (tail_q == '0);
    endsequence

    AST_CNT_SAT: assert property (
        !wr_counts && err_inc[0] && (cnt[0] == '1) |=> (cnt[0] == '1)
    ) else $error("counter wrapped past its top");

    AST_CNT_STEP: assert property (
        !wr_counts && err_inc[3] && (cnt[3] != '1)
        |=> (cnt[3] == $past(cnt[3]) + 8'h01)
    ) else $error("fast tx counter did not step by one");

    AST_FLAG_HOLD: assert property (
        !wr_flags && flags_q[5] |=> flags_q[5]
    ) else $error("crc flag dropped without a write");

    AST_FLAG_SET: assert property (
        flag_set[5] |=> flags_q[5]
    ) else $error("crc event lost against a clear");

    AST_RSV_ZERO: assert property (
        (flags_q & ~diag_pkg::FLAG_MASK) == '0
    ) else $error("reserved flag bit reads one");

    AST_CFG_HOLD: assert property (
        config_mode |=> (state_q == diag_pkg::TEF_RESET)
    ) else $error("reset bit not held in configuration mode");

    AST_RESET_DONE: assert property (
        s_reset_leave |=> s_run_empty
    ) else $error("fifo reset did not complete in one cycle");

    AST_POP: assert property (
        do_pop && !do_push |=> (fill_q == $past(fill_q) - 6'h01)
    ) else $error("tail advance did not remove one entry");

    AST_CFG_LOCK: assert property (
        !config_mode |=> $stable(depth_q) && $stable(stamp_en_q)
    ) else $error("depth or stamp enable changed outside configuration");

    AST_OV_IRQ: assert property (
        ov_q && ie_q[diag_pkg::OV_BIT] |=> tef_irq
    ) else $error("enabled overflow raised no interrupt");

    AST_FILL_BOUND: assert property (
        (state_q == diag_pkg::TEF_RUN) |-> (fill_q <= size)
    ) else $error("fill exceeds configured depth");
endmodule

// >>> bench/can_bus_peer.sv
// model of the protocol engine that reports events from the other bus nodes
// assumes callers sync to clk; every event line pulses for exactly one cycle
module can_bus_peer (
    input wire logic clk, // controller clock
    output logic [3:0] err_inc, // error pulses per phase
    output logic clean_msg, // clean message pulse
    output logic [15:0] flag_set, // flag event pulses
    output logic tef_push, // transmit event pulse
    output logic [31:0] time_base // free running stamp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] last_stamp;
    // stamp moves every cycle so each event carries a distinct value
    initial begin
        err_inc = 4'h0;
        clean_msg = 1'b0;
        flag_set = 16'h0000;
        tef_push = 1'b0;
        time_base = 32'h0000_1000;
        last_stamp = 32'h0000_0000;
        forever begin
            @(posedge clk);
            #1;
            time_base = time_base + 32'h0000_0001;
        end
    end
    // one event set for one cycle, then every line drops back to idle
    task automatic pulse(input logic [3:0] e, input logic c, input logic [15:0] f, input logic p);
        @(posedge clk);
        #1;
        err_inc = e;
        clean_msg = c;
        flag_set = f;
        tef_push = p;
        @(posedge clk);
        last_stamp = time_base;
        #1;
        err_inc = 4'h0;
        clean_msg = 1'b0;
        flag_set = 16'h0000;
        tef_push = 1'b0;
    endtask
endmodule

// >>> bench/can_diag_tef_test.sv
// self-checking bench for the diagnostic counters and event fifo control
// assumes the peer model drives all event inputs; registers via the index port
module can_diag_tef_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic rstn;
    logic reg_wr;
    logic [2:0] reg_addr;
    logic [31:0] reg_wdata;
    logic config_mode;
    logic [3:0] err_inc;
    logic clean_msg;
    logic [15:0] flag_set;
    logic tef_push;
    logic [31:0] time_base;
    logic [31:0] reg_rdata;
    logic tef_irq;
    int error_cnt;
    int checks;
    logic [31:0] v;
    logic [31:0] stamp_q[$];

    can_diag_tef u_can_diag_tef (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .config_mode(config_mode),
        .err_inc(err_inc), .clean_msg(clean_msg), .flag_set(flag_set),
        .tef_push(tef_push), .time_base(time_base), .reg_rdata(reg_rdata),
        .tef_irq(tef_irq));
    can_bus_peer u_can_bus_peer (.clk(clk), .err_inc(err_inc), .clean_msg(clean_msg),
        .flag_set(flag_set), .tef_push(tef_push), .time_base(time_base));

    // 25 MHz controller clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ----
    // helpers
    // ----
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_irq(input logic exp);
        checks++;
        if (tef_irq !== exp) begin
            error_cnt++;
            $display("[ERR] %0t irq %b expected %b", $time, tef_irq, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
    endtask
    // read data is registered, so it is taken one edge after the index
    task automatic rc(input logic [2:0] a, input logic [31:0] exp);
        @(posedge clk);
        #1;
        reg_addr = a;
        @(posedge clk);
        #1;
        chk_reg(reg_rdata, exp);
    endtask
    task automatic push(input int n);
        repeat (n) u_can_bus_peer.pulse(4'h0, 1'b0, 16'h0000, 1'b1);
    endtask
    task automatic done(input string name);
        $display("test %0s finished", name);
    endtask
    function automatic logic [31:0] tail_addr(input logic [31:0] tail, input logic ts = 1'b1);
        return diag_pkg::TEF_BASE + (ts ? diag_pkg::ENTRY_STAMPED : diag_pkg::ENTRY_PLAIN) * tail;
    endfunction
    function automatic logic [31:0] status(input int fill, input int ent, input logic ov);
        return {28'h0000000, ov, fill == ent, 2 * fill >= ent, fill != 0};
    endfunction

    // ----
    // main sequence
    // ----
    initial begin
        rstn = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 32'h0000_0000;
        config_mode = 1'b1;
        error_cnt = 0;
        checks = 0;
        void'($urandom(50));
        repeat (5) @(posedge clk);
        #1;
        rstn = 1'b1;
        rc(diag_pkg::IDX_COUNTS, 32'h0000_0000);
        rc(diag_pkg::IDX_FLAGS, 32'h0000_0000);
        rc(diag_pkg::IDX_TEFCON, 32'h0000_0400);
        rc(diag_pkg::IDX_TEFSTA, 32'h0000_0000);
        done("reset");
        // near-top values in each byte catch a counter that wraps
        for (int i = 0; i < 4; i++) begin
            v = $urandom;
            v[8*i +: 8] = 8'hfe;
            wr(diag_pkg::IDX_COUNTS, v);
            rc(diag_pkg::IDX_COUNTS, v);
            u_can_bus_peer.pulse(4'(1 << i), 1'b0, 16'h0000, 1'b0);
            v[8*i +: 8] = 8'hff;
            rc(diag_pkg::IDX_COUNTS, v);
            u_can_bus_peer.pulse(4'(1 << i), 1'b0, 16'h0000, 1'b0);
            rc(diag_pkg::IDX_COUNTS, v);
        end
        // a write lands in the same cycle as events on every counter
        fork
            wr(diag_pkg::IDX_COUNTS, 32'h0000_0000);
            u_can_bus_peer.pulse(4'hf, 1'b0, 16'h0000, 1'b0);
        join
        rc(diag_pkg::IDX_COUNTS, 32'h0000_0000);
        done("counters");
        v = $urandom;
        wr(diag_pkg::IDX_FLAGS, v);
        rc(diag_pkg::IDX_FLAGS, v & {diag_pkg::FLAG_MASK, 16'hffff});
        wr(diag_pkg::IDX_FLAGS, 32'h0000_fffe);
        v = 32'h0000_fffe;
        // one event at a time: flags must accumulate and stay set
        for (int k = 0; k < 16; k++) begin
            u_can_bus_peer.pulse(4'h0, 1'b0, 16'(1 << k), 1'b0);
            v[16+k] = diag_pkg::FLAG_MASK[k];
            rc(diag_pkg::IDX_FLAGS, v);
        end
        u_can_bus_peer.pulse(4'h0, 1'b1, 16'h0000, 1'b0);
        rc(diag_pkg::IDX_FLAGS, v | 32'h0000_0001);
        u_can_bus_peer.pulse(4'h0, 1'b1, 16'h0000, 1'b0);
        rc(diag_pkg::IDX_FLAGS, v | 32'h0000_0001);
        wr(diag_pkg::IDX_FLAGS, 32'h0000_0000);
        rc(diag_pkg::IDX_FLAGS, 32'h0000_0000);
        // a clear and a crc event in one cycle: the event must survive
        fork
            wr(diag_pkg::IDX_FLAGS, 32'h0000_0000);
            u_can_bus_peer.pulse(4'h0, 1'b0, 16'h0020, 1'b0);
        join
        rc(diag_pkg::IDX_FLAGS, 32'h0020_0000);
        wr(3'h6, $urandom);
        rc(3'h6, 32'h0000_0000);
        done("flags");
        // four entries, stamped, all interrupts on
        wr(diag_pkg::IDX_TEFCON, 32'h0300_002f);
        rc(diag_pkg::IDX_TEFCON, 32'h0300_042f);
        @(posedge clk);
        #1;
        config_mode = 1'b0;
        rc(diag_pkg::IDX_TEFCON, 32'h0300_002f);
        wr(diag_pkg::IDX_TEFCON, 32'h1f00_0004);
        rc(diag_pkg::IDX_TEFCON, 32'h0300_0024);
        for (int n = 1; n <= 4; n++) begin
            push(1);
            stamp_q.push_back(u_can_bus_peer.last_stamp);
            rc(diag_pkg::IDX_TEFSTA, status(n, 4, 1'b0));
            chk_irq(n == 4);
        end
        wr(diag_pkg::IDX_TEFCON, 32'h0000_0008);
        rc(diag_pkg::IDX_EVENT_TAIL_ADDRESS, tail_addr(0));
        chk_irq(1'b0);
        push(1);
        rc(diag_pkg::IDX_TEFSTA, status(4, 4, 1'b1));
        chk_irq(1'b1);
        rc(diag_pkg::IDX_STAMP, stamp_q[0]);
        done("fill");
        wr(diag_pkg::IDX_TEFCON, 32'h0000_0108);
        rc(diag_pkg::IDX_TEFCON, 32'h0300_0028);
        rc(diag_pkg::IDX_EVENT_TAIL_ADDRESS, tail_addr(1));
        rc(diag_pkg::IDX_STAMP, stamp_q[1]);
        rc(diag_pkg::IDX_TEFSTA, status(3, 4, 1'b1));
        wr(diag_pkg::IDX_TEFSTA, 32'h0000_0000);
        rc(diag_pkg::IDX_TEFSTA, status(3, 4, 1'b0));
        chk_irq(1'b0);
        wr(diag_pkg::IDX_TEFCON, 32'h0000_0002);
        rc(diag_pkg::IDX_TEFCON, 32'h0300_0022);
        chk_irq(1'b1);
        done("advance");
        // software waits for the reset bit to drop, but not forever
        wr(diag_pkg::IDX_TEFCON, 32'h0000_0403);
        v = 32'hffff_ffff;
        for (int t = 0; t < 20 && v[10] !== 1'b0; t++) begin
            @(posedge clk);
            #1;
            reg_addr = diag_pkg::IDX_TEFCON;
            @(posedge clk);
            #1;
            v = reg_rdata;
        end
        if (v[10] !== 1'b0) begin
            error_cnt++;
            $display("[ERR] %0t fifo reset never completed", $time);
            print_verdict();
        end
        rc(diag_pkg::IDX_TEFSTA, status(0, 4, 1'b0));
        rc(diag_pkg::IDX_EVENT_TAIL_ADDRESS, tail_addr(0));
        chk_irq(1'b0);
        done("fifo reset");
        // plain entries: the user address steps by the shorter entry size
        @(posedge clk);
        #1;
        config_mode = 1'b1;
        wr(diag_pkg::IDX_TEFCON, 32'h0100_0000);
        rc(diag_pkg::IDX_TEFCON, 32'h0100_0400);
        @(posedge clk);
        #1;
        config_mode = 1'b0;
        push(1);
        wr(diag_pkg::IDX_TEFCON, 32'h0000_0100);
        rc(diag_pkg::IDX_EVENT_TAIL_ADDRESS, tail_addr(1, 1'b0));
        rc(diag_pkg::IDX_TEFSTA, status(0, 2, 1'b0));
        done("plain entries");
        print_verdict();
    end
endmodule
